// ### rtl/hpc_device.sv
`timescale 1ns/1ns
`include "hpc_map.svh"

module hpc_device #(
	parameter int AW = 8
) (
	// clock and device reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// host-facing pins
	hpc_if.device bus,
	// core-side memory port
	input wire logic [AW-1:0] CORE_ADDR_I,
	input wire logic [15:0] CORE_WDATA_I,
	input wire logic CORE_WE_I,
	output logic [15:0] CORE_RDATA_O,
	// core-side events and status
	input wire logic CORE_IRQ_I,
	output logic HOST_WROTE_O,
	output logic PULLUP_EN_O,
	output logic HOLDER_EN_O,
	output logic WIDE_MODE_O,
	output logic PORT_ON_O
);

	hpc_pkg::hpc_dev_s s;
	hpc_pkg::hpc_dev_s next_s;
	logic [15:0] mem [0:(1 << AW) - 1];
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [15:0] mem_wdata;
	logic strobe;
	logic astrobe;
	logic [1:0] ctl;
	logic last;
	logic [15:0] val;
	logic [15:0] wdata;
	logic ack;

	// word index into the shared memory
	function automatic logic [AW-1:0] idx(input logic [15:0] a);
		idx = a[AW-1:0];
	endfunction

	// status word the host reads through the control register
	function automatic logic [15:0] ctrl_word(input hpc_pkg::hpc_dev_s st);
		ctrl_word = 16'h0000;
		ctrl_word[`HPC_CTRL_ACK_BIT] = st.irq_pend;
		ctrl_word[`HPC_CTRL_WIDE_BIT] = st.wide;
	endfunction

	// whole next-state computation
	always_comb begin
		next_s = s;
		next_s.host_wr = 1'b0;
		mem_we = 1'b0;
		mem_waddr = idx(s.addr);
		mem_wdata = `HPC_DATA_RST;
		val = `HPC_DATA_RST;
		wdata = `HPC_DATA_RST;
		ack = 1'b0;
		next_s.ds_prev = bus.data_strobe_n;
		next_s.as_prev = bus.addr_strobe_n;
		next_s.core_rdata = mem[CORE_ADDR_I];

		// straps caught on the first edge after release, then frozen
		if (!s.sampled) begin
			next_s.sampled = 1'b1;
			next_s.port_sel = bus.port_select_strap;
			next_s.wide = bus.wide_mode_strap;
			next_s.pull_en = !bus.port_select_strap;
			next_s.holder_en = !bus.port_select_strap;
		end

		// falling edges only, so a held strobe counts once
		strobe = s.port_sel && !bus.port_chip_select_n && !bus.data_strobe_n
			&& s.ds_prev && (s.state == hpc_pkg::DEV_IDLE);
		astrobe = s.port_sel && !bus.port_chip_select_n && !bus.addr_strobe_n
			&& s.as_prev;

		// wide mode ignores the control inputs and streams data
		ctl = s.wide ? `HPC_CTL_DATA_INC
			: {bus.reg_select_ctl1, bus.reg_select_ctl0};
		// narrow transfers complete on the second byte
		last = s.wide || bus.byte_ident;

		// multiplexed address capture
		if (astrobe) begin
			if (s.wide) begin
				next_s.addr = bus.host_data;
			end else if (bus.byte_ident) begin
				next_s.addr[7:0] = bus.host_data[7:0];
			end else begin
				next_s.addr[15:8] = bus.host_data[7:0];
			end
		end

		// data strobe handling
		if (strobe) begin
			if (bus.transfer_dir_select == `HPC_DIR_READ) begin
				case (ctl)
					`HPC_CTL_CONTROL: val = ctrl_word(s);
					`HPC_CTL_ADDR: val = s.addr;
					default: val = mem[idx(s.addr)];
				endcase
				if (s.wide) begin
					next_s.d2h = val;
				end else if (!bus.byte_ident) begin
					next_s.word = val;
					next_s.d2h = {8'h00, val[15:8]};
				end else begin
					next_s.d2h = {8'h00, s.word[7:0]};
				end
			end else begin
				wdata = s.wide ? bus.host_data
					: {s.first_byte, bus.host_data[7:0]};
				if (!last) begin
					next_s.first_byte = bus.host_data[7:0];
				end else begin
					case (ctl)
						`HPC_CTL_CONTROL: ack = wdata[`HPC_CTRL_ACK_BIT];
						`HPC_CTL_ADDR: next_s.addr = wdata;
						default: begin
							mem_we = 1'b1;
							mem_wdata = wdata;
							next_s.host_wr = 1'b1;
						end
					endcase
				end
			end
			// auto-increment once per completed data word
			if (last && (ctl == `HPC_CTL_DATA_INC)) begin
				next_s.addr = s.addr + 16'h0001;
			end
			next_s.state = hpc_pkg::DEV_BUSY;
			next_s.cnt = `HPC_BUSY_CYCLES - 4'h1;
			next_s.ready = 1'b0;
		end

		// busy count before the next transfer may start
		case (s.state)
			hpc_pkg::DEV_IDLE: begin
			end
			hpc_pkg::DEV_BUSY: begin
				if (s.cnt == 4'h0) begin
					next_s.state = hpc_pkg::DEV_IDLE;
					next_s.ready = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 4'h1;
				end
			end
			default: begin
				next_s.state = hpc_pkg::DEV_IDLE;
				next_s.ready = 1'b1;
			end
		endcase

		// core request sets outside wide mode, host ack clears; a set in the clear cycle wins
		if (ack) begin
			next_s.irq_pend = 1'b0;
		end
		if (CORE_IRQ_I && !next_s.wide) begin
			next_s.irq_pend = 1'b1;
		end
		// wide mode parks the pin high instead of floating it
		next_s.irq_n = !next_s.irq_pend || next_s.wide;

		// output disable is a plain level, one flop of delay
		next_s.outs_oe = bus.outputs_off_n;
		next_s.d2h_oe = s.port_sel && bus.outputs_off_n && !bus.port_chip_select_n
			&& (bus.transfer_dir_select == `HPC_DIR_READ);
	end

	// state register; reset constants keep ready and irq high
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s <= '0;
			s.pull_en <= 1'b1;
			s.holder_en <= 1'b1;
			s.addr <= `HPC_ADDR_RST;
			s.state <= hpc_pkg::DEV_IDLE;
			s.ready <= 1'b1;
			s.outs_oe <= 1'b1;
			s.irq_n <= 1'b1;
			s.ds_prev <= 1'b1;
			s.as_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// memory kept outside the struct; host write beats core write
	always_ff @(posedge CLK_I) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end else if (CORE_WE_I) begin
			mem[CORE_ADDR_I] <= CORE_WDATA_I;
		end
	end

	// pins and core outputs, all straight from flops
	assign bus.host_ready_out = s.ready;
	assign bus.host_ready_oe = s.outs_oe;
	assign bus.host_irq_out_n = s.irq_n;
	assign bus.host_irq_oe = s.outs_oe;
	assign bus.dev_data = s.d2h;
	assign bus.dev_data_oe = s.d2h_oe;
	assign CORE_RDATA_O = s.core_rdata;
	assign HOST_WROTE_O = s.host_wr;
	assign PULLUP_EN_O = s.pull_en;
	assign HOLDER_EN_O = s.holder_en;
	assign WIDE_MODE_O = s.wide;
	assign PORT_ON_O = s.port_sel;

endmodule

// ### rtl/hpc_map.svh
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

// register select codes carried on the two control inputs
`define HPC_CTL_CONTROL 2'h0
`define HPC_CTL_DATA_INC 2'h1
`define HPC_CTL_ADDR 2'h2
`define HPC_CTL_DATA 2'h3

// control word field positions
`define HPC_CTRL_ACK_BIT 0
`define HPC_CTRL_WIDE_BIT 1

// reset values
`define HPC_ADDR_RST 16'h0000
`define HPC_DATA_RST 16'h0000

// cycles the ready output stays low after a data strobe
`define HPC_BUSY_CYCLES 4'h3

// transfer direction level meaning read
`define HPC_DIR_READ 1'b1

`endif

// ### rtl/hpc_pkg.sv
package hpc_pkg;

	typedef enum logic [0:0] {
		DEV_IDLE,
		DEV_BUSY
	} hpc_dev_e;

	typedef enum logic [2:0] {
		HST_IDLE,
		HST_SETUP,
		HST_STROBE,
		HST_GAP,
		HST_WAIT,
		HST_NEXT,
		HST_FINISH
	} hpc_host_e;

	typedef enum logic [1:0] {
		REQ_ADDR_LATCH,
		REQ_WRITE,
		REQ_READ
	} hpc_req_e;

	typedef struct packed {
		logic sampled;
		logic port_sel;
		logic wide;
		logic pull_en;
		logic holder_en;
		logic [15:0] addr;
		logic [7:0] first_byte;
		logic [15:0] word;
		hpc_dev_e state;
		logic [3:0] cnt;
		logic ready;
		logic outs_oe;
		logic irq_pend;
		logic irq_n;
		logic ds_prev;
		logic as_prev;
		logic [15:0] d2h;
		logic d2h_oe;
		logic [15:0] core_rdata;
		logic host_wr;
	} hpc_dev_s;

	typedef struct packed {
		hpc_host_e state;
		hpc_req_e kind;
		logic [1:0] ctl;
		logic [15:0] data;
		logic cs_n;
		logic as_n;
		logic ds_n;
		logic dir;
		logic byte_ident;
		logic [15:0] h2d;
		logic sel_strap;
		logic wide_strap;
		logic off_n;
		logic busy;
		logic done;
		logic [15:0] rdata;
		logic irq;
	} hpc_host_s;

endpackage

// ### rtl/hpc_if.sv
`timescale 1ns/1ns

// pin bundle between the host processor and the device port
interface hpc_if;
	logic port_chip_select_n;
	logic addr_strobe_n;
	logic data_strobe_n;
	logic transfer_dir_select;
	logic reg_select_ctl0;
	logic reg_select_ctl1;
	logic byte_ident;
	logic [15:0] host_data;
	logic [15:0] dev_data;
	logic dev_data_oe;
	logic host_ready_out;
	logic host_ready_oe;
	logic host_irq_out_n;
	logic host_irq_oe;
	logic port_select_strap;
	logic wide_mode_strap;
	logic outputs_off_n;

	modport device (
		input port_chip_select_n, addr_strobe_n, data_strobe_n, transfer_dir_select,
		input reg_select_ctl0, reg_select_ctl1, byte_ident, host_data,
		input port_select_strap, wide_mode_strap, outputs_off_n,
		output dev_data, dev_data_oe, host_ready_out, host_ready_oe,
		output host_irq_out_n, host_irq_oe
	);

	modport host (
		output port_chip_select_n, addr_strobe_n, data_strobe_n, transfer_dir_select,
		output reg_select_ctl0, reg_select_ctl1, byte_ident, host_data,
		output port_select_strap, wide_mode_strap, outputs_off_n,
		input dev_data, dev_data_oe, host_ready_out, host_ready_oe,
		input host_irq_out_n, host_irq_oe
	);
endinterface

// ### rtl/hpc_host.sv
`timescale 1ns/1ns
`include "hpc_map.svh"

module hpc_host (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// device pins
	hpc_if.host bus,
	// request from the host's own logic
	input wire logic REQ_I,
	input wire hpc_pkg::hpc_req_e REQ_KIND_I,
	input wire logic [1:0] REQ_CTL_I,
	input wire logic [15:0] REQ_DATA_I,
	// board straps and test disable
	input wire logic PORT_SELECT_I,
	input wire logic WIDE_MODE_I,
	input wire logic OFF_N_I,
	// answer
	output logic BUSY_O,
	output logic DONE_O,
	output logic [15:0] RDATA_O,
	output logic IRQ_O
);

	hpc_pkg::hpc_host_s s;
	hpc_pkg::hpc_host_s next_s;
	logic ready;

	// ready counts only while the device actually drives it
	assign ready = bus.host_ready_out && bus.host_ready_oe;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		// straps follow the board; it must keep select steady out of reset
		next_s.sel_strap = PORT_SELECT_I;
		next_s.wide_strap = WIDE_MODE_I;
		next_s.off_n = OFF_N_I;
		next_s.irq = !bus.host_irq_out_n && bus.host_irq_oe && !s.wide_strap;
		case (s.state)
			hpc_pkg::HST_IDLE: begin
				if (REQ_I) begin
					next_s.kind = REQ_KIND_I;
					next_s.ctl = REQ_CTL_I;
					next_s.data = REQ_DATA_I;
					next_s.busy = 1'b1;
					next_s.cs_n = 1'b0;
					next_s.byte_ident = 1'b0;
					next_s.dir = (REQ_KIND_I == hpc_pkg::REQ_READ);
					next_s.h2d = s.wide_strap ? REQ_DATA_I : {8'h00, REQ_DATA_I[15:8]};
					next_s.state = hpc_pkg::HST_SETUP;
				end
			end
			hpc_pkg::HST_SETUP: begin
				// no strobe until the device says it can take one
				if (ready) begin
					next_s.state = hpc_pkg::HST_STROBE;
					if (s.kind == hpc_pkg::REQ_ADDR_LATCH) begin
						next_s.as_n = 1'b0;
					end else begin
						next_s.ds_n = 1'b0;
					end
				end
			end
			hpc_pkg::HST_STROBE: begin
				next_s.as_n = 1'b1;
				next_s.ds_n = 1'b1;
				next_s.state = (s.kind == hpc_pkg::REQ_ADDR_LATCH)
					? hpc_pkg::HST_NEXT : hpc_pkg::HST_GAP;
			end
			hpc_pkg::HST_GAP: begin
				// skip the stale ready high left from before the strobe
				next_s.state = hpc_pkg::HST_WAIT;
			end
			hpc_pkg::HST_WAIT: begin
				if (ready) begin
					next_s.state = hpc_pkg::HST_NEXT;
					if (s.dir) begin
						if (s.wide_strap) begin
							next_s.rdata = bus.dev_data;
						end else if (!s.byte_ident) begin
							next_s.rdata[15:8] = bus.dev_data[7:0];
						end else begin
							next_s.rdata[7:0] = bus.dev_data[7:0];
						end
					end
				end
			end
			hpc_pkg::HST_NEXT: begin
				if (!s.wide_strap && !s.byte_ident) begin
					next_s.byte_ident = 1'b1;
					next_s.h2d = {8'h00, s.data[7:0]};
					next_s.state = hpc_pkg::HST_SETUP;
				end else begin
					next_s.state = hpc_pkg::HST_FINISH;
				end
			end
			hpc_pkg::HST_FINISH: begin
				next_s.cs_n = 1'b1;
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.state = hpc_pkg::HST_IDLE;
			end
			default: next_s.state = hpc_pkg::HST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s <= '0;
			s.state <= hpc_pkg::HST_IDLE;
			s.cs_n <= 1'b1;
			s.as_n <= 1'b1;
			s.ds_n <= 1'b1;
			s.dir <= 1'b1;
			s.off_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// pins driven from the state register
	assign bus.port_chip_select_n = s.cs_n;
	assign bus.addr_strobe_n = s.as_n;
	assign bus.data_strobe_n = s.ds_n;
	assign bus.transfer_dir_select = s.dir;
	assign bus.reg_select_ctl0 = s.ctl[0];
	assign bus.reg_select_ctl1 = s.ctl[1];
	assign bus.byte_ident = s.byte_ident;
	assign bus.host_data = s.h2d;
	assign bus.port_select_strap = s.sel_strap;
	assign bus.wide_mode_strap = s.wide_strap;
	assign bus.outputs_off_n = s.off_n;
	assign BUSY_O = s.busy;
	assign DONE_O = s.done;
	assign RDATA_O = s.rdata;
	assign IRQ_O = s.irq;

endmodule

// ### sim/hpc_assertions.sv
`timescale 1ns/1ns
// watches the pins between host and device
module hpc_assertions (
	// clock and device reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// host-driven pins
	input wire logic port_chip_select_n,
	input wire logic data_strobe_n,
	input wire logic transfer_dir_select,
	input wire logic outputs_off_n,
	input wire logic port_select_strap,
	input wire logic wide_mode_strap,
	// device-driven pins
	input wire logic dev_data_oe,
	input wire logic host_ready_out,
	input wire logic host_ready_oe,
	input wire logic host_irq_out_n,
	input wire logic host_irq_oe
);
	logic armed;
	logic sel_q;
	logic wide_q;
	logic clk_seen = 1'b0;
	default clocking cb @(posedge CLK_I); endclocking
	// pins are unknown until the first edge has applied the reset
	always @(posedge CLK_I) begin
		clk_seen <= 1'b1;
	end
	default disable iff (!RESET_N_I);
	// own copy of the straps, frozen like the device's, so later strap changes mislead nothing
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			armed <= 1'b0;
			sel_q <= 1'b0;
			wide_q <= 1'b0;
		end else if (!armed) begin
			armed <= 1'b1;
			sel_q <= port_select_strap;
			wide_q <= wide_mode_strap;
		end
	end
	property p_rdy_rst;
		disable iff (1'b0) !RESET_N_I && clk_seen |-> host_ready_out && host_ready_oe;
	endproperty
	a_rdy_rst: assert property (p_rdy_rst) else $error("ready low in reset");
	property p_irq_rst;
		disable iff (1'b0) !RESET_N_I && clk_seen |-> host_irq_out_n && host_irq_oe;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq low in reset");
	property p_take;
		$fell(data_strobe_n) && !port_chip_select_n && host_ready_out && sel_q |=> !host_ready_out;
	endproperty
	a_take: assert property (p_take) else $error("strobe not taken");
	property p_busy3;
		$fell(host_ready_out) |=> !host_ready_out ##1 !host_ready_out ##1 host_ready_out;
	endproperty
	a_busy3: assert property (p_busy3) else $error("busy time wrong");
	property p_off;
		!outputs_off_n |=> !host_ready_oe && !host_irq_oe;
	endproperty
	a_off: assert property (p_off) else $error("outputs not floated");
	property p_on;
		outputs_off_n |=> host_ready_oe && host_irq_oe;
	endproperty
	a_on: assert property (p_on) else $error("outputs floated");
	property p_wide_irq;
		wide_q |-> host_irq_out_n;
	endproperty
	a_wide_irq: assert property (p_wide_irq) else $error("irq used in wide mode");
	property p_irq_ack;
		$rose(host_irq_out_n) |-> !$past(data_strobe_n);
	endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("irq cleared without access");
	property p_rd_oe;
		!port_chip_select_n && transfer_dir_select && outputs_off_n && sel_q |=> dev_data_oe;
	endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
	property p_desel;
		armed && !sel_q |-> host_ready_out;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected port went busy");
endmodule

// ### sim/host_port_pin_control_tb.sv
`timescale 1ns/1ns
// host and device joined back to back
module host_port_pin_control_tb;
	logic clk = 1'b0;
	logic host_rst_n = 1'b0;
	logic dev_rst_n = 1'b0;
	logic req = 1'b0;
	hpc_pkg::hpc_req_e req_kind = hpc_pkg::REQ_ADDR_LATCH;
	logic [1:0] req_ctl = 2'h0;
	logic [15:0] req_data = 16'h0000;
	logic sel = 1'b1;
	logic wide = 1'b0;
	logic off_n = 1'b1;
	logic [7:0] core_addr = 8'h00;
	logic [15:0] core_wdata = 16'h0000;
	logic core_we = 1'b0;
	logic core_irq = 1'b0;
	logic busy, done, irq_seen, host_wrote, pullup_en, holder_en, wide_mode, port_on;
	logic [15:0] rdata;
	logic [15:0] core_rdata;
	int errors = 0;
	int total_checks = 0;
	logic [15:0] wr_count = 16'h0000;
	// counts committed host writes; falling edge keeps clear of the launching edge
	always @(negedge clk) begin
		if (host_wrote === 1'b1) begin
			wr_count <= wr_count + 16'h0001;
		end
	end
	hpc_if bus ();
	// 25 MHz clock
	always #20 clk = ~clk;
	hpc_device #(.AW(8)) hpc_device_inst (.CLK_I(clk), .RESET_N_I(dev_rst_n), .bus(bus),
		.CORE_ADDR_I(core_addr), .CORE_WDATA_I(core_wdata), .CORE_WE_I(core_we),
		.CORE_RDATA_O(core_rdata), .CORE_IRQ_I(core_irq), .HOST_WROTE_O(host_wrote),
		.PULLUP_EN_O(pullup_en), .HOLDER_EN_O(holder_en), .WIDE_MODE_O(wide_mode),
		.PORT_ON_O(port_on));
	hpc_host hpc_host_inst (.CLK_I(clk), .RESET_N_I(host_rst_n), .bus(bus), .REQ_I(req),
		.REQ_KIND_I(req_kind), .REQ_CTL_I(req_ctl), .REQ_DATA_I(req_data),
		.PORT_SELECT_I(sel), .WIDE_MODE_I(wide), .OFF_N_I(off_n), .BUSY_O(busy),
		.DONE_O(done), .RDATA_O(rdata), .IRQ_O(irq_seen));
	hpc_assertions hpc_assertions_inst (.CLK_I(clk), .RESET_N_I(dev_rst_n),
		.port_chip_select_n(bus.port_chip_select_n), .data_strobe_n(bus.data_strobe_n),
		.transfer_dir_select(bus.transfer_dir_select), .outputs_off_n(bus.outputs_off_n),
		.port_select_strap(bus.port_select_strap), .wide_mode_strap(bus.wide_mode_strap),
		.dev_data_oe(bus.dev_data_oe), .host_ready_out(bus.host_ready_out),
		.host_ready_oe(bus.host_ready_oe), .host_irq_out_n(bus.host_irq_out_n),
		.host_irq_oe(bus.host_irq_oe));
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one host request, waits for its done pulse under a bound
	task automatic op(input hpc_pkg::hpc_req_e k, input logic [1:0] c, input logic [15:0] d);
		int n;
		req = 1'b1;
		req_kind = k;
		req_ctl = c;
		req_data = d;
		@(posedge clk);
		#1 req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		check("done", n < 200, 1'b1);
		check("busy", busy, 1'b0);
	endtask
	// this task changes the straps only while the device sits in reset
	task automatic dev_reset(input logic s, input logic w);
		dev_rst_n = 1'b0;
		sel = s;
		wide = w;
		repeat (4) @(posedge clk);
		#1 check("ready_rst", bus.host_ready_out, 1'b1);
		check("irq_rst", bus.host_irq_out_n, 1'b1);
		dev_rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic core_wr(input logic [7:0] a, input logic [15:0] d);
		core_addr = a;
		core_wdata = d;
		core_we = 1'b1;
		@(posedge clk);
		#1 core_we = 1'b0;
	endtask
	task automatic core_rd(input logic [7:0] a, input logic [15:0] exp);
		core_addr = a;
		@(posedge clk);
		#1 check("core_rdata", core_rdata, exp);
	endtask
	task automatic irq_pulse();
		core_irq = 1'b1;
		@(posedge clk);
		#1 core_irq = 1'b0;
	endtask
	// watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		finish_test();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		#1 host_rst_n = 1'b1;
		dev_reset(1'b1, 1'b0);
		check("port_on", port_on, 1'b1);
		check("wide_mode", wide_mode, 1'b0);
		check("pullup_en", pullup_en, 1'b0);
		check("holder_en", holder_en, 1'b0);
		op(hpc_pkg::REQ_ADDR_LATCH, 2'h2, 16'h0010);
		op(hpc_pkg::REQ_WRITE, 2'h3, 16'habcd);
		core_rd(8'h10, 16'habcd);
		core_wr(8'h11, 16'h1234);
		op(hpc_pkg::REQ_ADDR_LATCH, 2'h2, 16'h0011);
		op(hpc_pkg::REQ_READ, 2'h3, 16'h0000);
		check("rdata", rdata, 16'h1234);
		op(hpc_pkg::REQ_ADDR_LATCH, 2'h2, 16'h0020);
		op(hpc_pkg::REQ_WRITE, 2'h1, 16'h1111);
		op(hpc_pkg::REQ_WRITE, 2'h1, 16'h2222);
		core_rd(8'h20, 16'h1111);
		core_rd(8'h21, 16'h2222);
		op(hpc_pkg::REQ_READ, 2'h2, 16'h0000);
		check("addr_reg", rdata, 16'h0022);
		irq_pulse();
		check("irq_set", bus.host_irq_out_n, 1'b0);
		repeat (5) @(posedge clk);
		#1 check("irq_hold", bus.host_irq_out_n, 1'b0);
		check("irq_seen", irq_seen, 1'b1);
		op(hpc_pkg::REQ_READ, 2'h0, 16'h0000);
		check("ctrl_word", rdata, 16'h0001);
		op(hpc_pkg::REQ_WRITE, 2'h0, 16'h0001);
		check("irq_ack", bus.host_irq_out_n, 1'b1);
		off_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 check("ready_oe", bus.host_ready_oe, 1'b0);
		check("irq_oe", bus.host_irq_oe, 1'b0);
		off_n = 1'b1;
		sel = 1'b0;
		repeat (4) @(posedge clk);
		#1 check("port_kept", port_on, 1'b1);
		dev_reset(1'b1, 1'b1);
		check("wide_mode", wide_mode, 1'b1);
		op(hpc_pkg::REQ_ADDR_LATCH, 2'h2, 16'h0030);
		op(hpc_pkg::REQ_WRITE, 2'h3, 16'h5a5a);
		op(hpc_pkg::REQ_WRITE, 2'h3, 16'ha5a5);
		core_rd(8'h30, 16'h5a5a);
		core_rd(8'h31, 16'ha5a5);
		irq_pulse();
		repeat (3) @(posedge clk);
		#1 check("irq_wide", bus.host_irq_out_n, 1'b1);
		dev_reset(1'b0, 1'b0);
		check("port_off", port_on, 1'b0);
		check("pullup_on", pullup_en, 1'b1);
		check("holder_on", holder_en, 1'b1);
		core_wr(8'h40, 16'h0000);
		op(hpc_pkg::REQ_ADDR_LATCH, 2'h2, 16'h0040);
		op(hpc_pkg::REQ_WRITE, 2'h3, 16'h7777);
		core_rd(8'h40, 16'h0000);
		check("host_wrote", wr_count, 16'h0005);
		finish_test();
	end
endmodule
